//--- hdl/scan_status_regs.sv
// Scan status register bank: potentiometers, constant scan, state monitor.
// Assumes a host sequencer that pulses end_of_scan and keeps relays steady
// while scan_busy is high.
//
// The placing of the registers and the plain strobed port are this design's own decisions.
module scan_status_regs #(
  parameter int MS_CYCLES = scan_status_pkg::MS_CYCLES
) (
  // Clock and reset.
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // Register port.
  input  wire scan_status_pkg::reg_req_t reg_req,
  output logic      [15:0]               reg_rdata_ff,
  // Relay image updates from the sequencer.
  input  wire scan_status_pkg::relay_wr_t relay_wr,
  // Front potentiometers.
  input  wire logic [7:0]                front_pot_one,
  input  wire logic [7:0]                front_pot_two,
  // Scan sequencing.
  input  wire logic                      end_of_scan,
  output logic                           scan_busy,
  output logic                           constant_scan_wait
);

  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_EXAM, ST_COMMIT} sweep_t;

  sweep_t            state_ff;
  logic [7:0]        pot_one_ff;
  logic [7:0]        pot_two_ff;
  logic [15:0]       const_scan_ff;
  logic [2:0]        ctrl_ff;
  logic [7:0][15:0]  slot_ff;
  logic [7:0][15:0]  shadow_ff;
  logic [15:0]       ann_min_ff;
  logic [3:0]        count_ff;
  logic [7:0]        word_ff;
  logic [15:0]       taken_ff;
  logic              ann_hit_ff;
  logic [11:0]       ann_num_ff;
  logic [17:0]       div_ff;
  logic [15:0]       elapsed_ff;
  logic [15:0]       rd_word;
  logic [15:0]       step_mask;
  logic [15:0]       ann_mask;
  logic              step_found;
  logic [3:0]        step_idx;
  logic              ann_found;
  logic [3:0]        ann_idx;
  logic [11:0]       found_num;
  logic              take;
  logic              commit;
  logic              ms_tick;
  logic              constant_scan_enable;
  logic              state_monitor_enable;
  logic              annunciator_monitor_enable;
  logic [15:0]       nxt_rdata;

  assign constant_scan_enable = ctrl_ff[scan_status_pkg::CTRL_CSCAN_BIT];
  assign state_monitor_enable = ctrl_ff[scan_status_pkg::CTRL_SMON_BIT];
  assign annunciator_monitor_enable =
    ctrl_ff[scan_status_pkg::CTRL_AMON_BIT];

  // The relay image lives in its own memory; the sweep reads a word a time.
  relay_image_mem #(
    .WIDTH (scan_status_pkg::WORD_BITS),
    .DEPTH (scan_status_pkg::IMAGE_WORDS),
    .AW    (8),
    .BW    (4)
  ) u_image (
    .clk        (clk),
    .rst_n      (rst_n),
    .wr_en      (relay_wr.valid),
    .wr_addr    (relay_wr.num[11:4]),
    .wr_bit     (relay_wr.num[3:0]),
    .wr_val     (relay_wr.on),
    .rd_en      (state_ff == ST_READ),
    .rd_addr    (word_ff),
    .rd_data_ff (rd_word)
  );

  // Split each word into step and annunciator bits by relay number.
  always_comb
  begin
    logic [11:0] num;
    num = '0;
    for (int b = 0; b < scan_status_pkg::WORD_BITS; b++)
    begin
      num = {word_ff, 4'(b)};
      ann_mask[b] = (num >= scan_status_pkg::ANN_FIRST_NUM) &&
                    (num <= scan_status_pkg::ANN_LAST_NUM);
      step_mask[b] = !ann_mask[b];
    end
  end

  // Step states not yet reported from this word.
  lowest_bit_finder #(
    .WIDTH (16),
    .IW    (4)
  ) u_step_find (
    .word  (rd_word & step_mask & ~taken_ff),
    .found (step_found),
    .idx   (step_idx)
  );

  // Annunciators in this word.
  lowest_bit_finder #(
    .WIDTH (16),
    .IW    (4)
  ) u_ann_find (
    .word  (rd_word & ann_mask),
    .found (ann_found),
    .idx   (ann_idx)
  );

  assign found_num = {word_ff, step_idx};
  assign take = (state_ff == ST_EXAM) && step_found &&
                (count_ff < 4'(scan_status_pkg::SLOT_COUNT));
  assign commit = (state_ff == ST_COMMIT);
  assign scan_busy = (state_ff != ST_IDLE);

  // Sweep sequencer: started by end_of_scan, words visited in ascending
  // order; a new end_of_scan during a sweep is ignored.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state_ff <= ST_IDLE;
    else
      unique case (state_ff)
        ST_IDLE:   if (end_of_scan) state_ff <= ST_READ;
        ST_READ:   state_ff <= ST_EXAM;
        ST_EXAM:
          if (!take)
            state_ff <= (word_ff == scan_status_pkg::LAST_WORD) ?
                        ST_COMMIT : ST_READ;
        ST_COMMIT: state_ff <= ST_IDLE;
      endcase
  end

  // Word pointer and the bits already reported from the current word.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      word_ff  <= '0;
      taken_ff <= '0;
    end
    else if (state_ff == ST_IDLE)
    begin
      word_ff  <= '0;
      taken_ff <= '0;
    end
    else if (take)
      taken_ff[step_idx] <= 1'b1;
    else if (state_ff == ST_EXAM)
    begin
      word_ff  <= word_ff + 8'h01;
      taken_ff <= '0;
    end
  end

  // Collect up to eight step states in ascending order; the shadow starts
  // cleared so unfilled slots commit as zero.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      shadow_ff <= '0;
      count_ff  <= '0;
    end
    else if (state_ff == ST_IDLE && end_of_scan)
    begin
      shadow_ff <= '0;
      count_ff  <= '0;
    end
    else if (take)
    begin
      shadow_ff[count_ff[2:0]] <= {4'h0, found_num};
      count_ff <= count_ff + 4'h1;
    end
  end

  // Lowest annunciator: only the first hit of the sweep is kept.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ann_hit_ff <= 1'b0;
      ann_num_ff <= '0;
    end
    else if (state_ff == ST_IDLE && end_of_scan)
      ann_hit_ff <= 1'b0;
    else if (state_ff == ST_EXAM && ann_found && !ann_hit_ff)
    begin
      ann_hit_ff <= 1'b1;
      ann_num_ff <= {word_ff, ann_idx};
    end
  end

  // Monitor slots change only in the commit cycle of a sweep.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      slot_ff <= '0;
    else if (commit && state_monitor_enable)
      slot_ff <= shadow_ff;
  end

  // Annunciator minimum; zero when no annunciator is active.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ann_min_ff <= '0;
    else if (commit && annunciator_monitor_enable)
      ann_min_ff <= ann_hit_ff ? {4'h0, ann_num_ff} : 16'h0000;
  end

  // Potentiometers are sampled on the end_of_scan pulse itself, ahead of the other monitors, which wait for the commit.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pot_one_ff <= '0;
      pot_two_ff <= '0;
    end
    else if (end_of_scan)
    begin
      pot_one_ff <= front_pot_one;
      pot_two_ff <= front_pot_two;
    end
  end

  // Duration loads its default at power-on and takes software writes.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      const_scan_ff <= scan_status_pkg::CONST_SCAN_RESET;
    else if (reg_req.wr && reg_req.addr == scan_status_pkg::OFS_CONST_SCAN)
      const_scan_ff <= reg_req.wdata;
  end

  // Control bits.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ctrl_ff <= scan_status_pkg::CONTROL_RESET;
    else if (reg_req.wr && reg_req.addr == scan_status_pkg::OFS_CONTROL)
      ctrl_ff <= reg_req.wdata[2:0];
  end

  // Millisecond divider, restarted at end of scan so the first unit is full.
  assign ms_tick = (div_ff == 18'(MS_CYCLES - 1));

  always_ff @(posedge clk)
  begin
    if (!rst_n || end_of_scan || ms_tick)
      div_ff <= '0;
    else
      div_ff <= div_ff + 18'h00001;
  end

  // Milliseconds since the last end of scan, saturating.
  always_ff @(posedge clk)
  begin
    if (!rst_n || end_of_scan)
      elapsed_ff <= '0;
    else if (ms_tick && elapsed_ff != 16'hffff)
      elapsed_ff <= elapsed_ff + 16'h0001;
  end

  // The sequencer holds the next scan while this is high.
  assign constant_scan_wait = constant_scan_enable &&
                              (elapsed_ff < const_scan_ff);

  // Read multiplexer; unmapped addresses read as zero.
  always_comb
  begin
    nxt_rdata = '0;
    if (reg_req.addr[7:3] == scan_status_pkg::OFS_SLOT_BASE[7:3])
      nxt_rdata = slot_ff[reg_req.addr[2:0]];
    else
      case (reg_req.addr)
        scan_status_pkg::OFS_POT_ONE:    nxt_rdata = {8'h00, pot_one_ff};
        scan_status_pkg::OFS_POT_TWO:    nxt_rdata = {8'h00, pot_two_ff};
        scan_status_pkg::OFS_CONST_SCAN: nxt_rdata = const_scan_ff;
        scan_status_pkg::OFS_STATUS:
          nxt_rdata = {14'h0000, constant_scan_wait, scan_busy};
        scan_status_pkg::OFS_CONTROL:    nxt_rdata = {13'h0000, ctrl_ff};
        scan_status_pkg::OFS_ANN_MIN:    nxt_rdata = ann_min_ff;
        default:                         nxt_rdata = '0;
      endcase
  end

  // Read data stand for exactly the cycle after the read strobe.
  always_ff @(posedge clk)
  begin
    if (!rst_n || !reg_req.rd)
      reg_rdata_ff <= '0;
    else
      reg_rdata_ff <= nxt_rdata;
  end

  property p_pot_one;
    @(posedge clk) disable iff (!rst_n)
    reg_req.rd && reg_req.addr == scan_status_pkg::OFS_POT_ONE |=>
      reg_rdata_ff == {8'h00, $past(pot_one_ff)};
  endproperty
  a_pot_one: assert property (p_pot_one)
    else $error("Potentiometer one read mismatch.");

  property p_pot_two;
    @(posedge clk) disable iff (!rst_n)
    reg_req.rd && reg_req.addr == scan_status_pkg::OFS_POT_TWO |=>
      reg_rdata_ff[15:8] == 8'h00 && reg_rdata_ff[7:0] == $past(pot_two_ff);
  endproperty
  a_pot_two: assert property (p_pot_two)
    else $error("Potentiometer two read mismatch.");

  property p_cscan_default;
    @(posedge clk) $rose(rst_n) |-> const_scan_ff == 16'h0000;
  endproperty
  a_cscan_default: assert property (p_cscan_default)
    else $error("Constant scan duration not zero after reset.");

  property p_cscan_write;
    @(posedge clk) disable iff (!rst_n)
    reg_req.wr && reg_req.addr == scan_status_pkg::OFS_CONST_SCAN ##1
      reg_req.rd && reg_req.addr == scan_status_pkg::OFS_CONST_SCAN |=>
      reg_rdata_ff == $past(reg_req.wdata, 2);
  endproperty
  a_cscan_write: assert property (p_cscan_write)
    else $error("Written constant scan duration not read back.");

  property p_first_slot;
    @(posedge clk) disable iff (!rst_n)
    take && count_ff == 4'h0 |=> shadow_ff[0] == {4'h0, $past(found_num)};
  endproperty
  a_first_slot: assert property (p_first_slot)
    else $error("First active state not placed in slot one.");

  property p_ascending;
    @(posedge clk) disable iff (!rst_n)
    commit && state_monitor_enable |=>
      (slot_ff[1] > slot_ff[0] || slot_ff[1] == 16'h0000) &&
      (slot_ff[7] > slot_ff[6] || slot_ff[7] == 16'h0000);
  endproperty
  a_ascending: assert property (p_ascending)
    else $error("Monitor slots not ascending.");

  property p_ann_min;
    @(posedge clk) disable iff (!rst_n)
    commit && annunciator_monitor_enable && ann_hit_ff |=>
      ann_min_ff == {4'h0, $past(ann_num_ff)} && ann_min_ff >= 16'h0384;
  endproperty
  a_ann_min: assert property (p_ann_min)
    else $error("Annunciator minimum not stored.");

  property p_refresh_only;
    @(posedge clk) disable iff (!rst_n)
    !commit |=> $stable(slot_ff) && $stable(ann_min_ff);
  endproperty
  a_refresh_only: assert property (p_refresh_only)
    else $error("Monitor changed outside end-of-scan refresh.");

  property p_clear_unused;
    @(posedge clk) disable iff (!rst_n)
    commit && state_monitor_enable && count_ff < 4'h8 |=>
      slot_ff[7] == 16'h0000;
  endproperty
  a_clear_unused: assert property (p_clear_unused)
    else $error("Unused monitor slot not cleared.");

  property p_hold_disabled;
    @(posedge clk) disable iff (!rst_n)
    commit && !state_monitor_enable |=> $stable(slot_ff);
  endproperty
  a_hold_disabled: assert property (p_hold_disabled)
    else $error("Monitor slots changed while disabled.");

endmodule : scan_status_regs

//--- inc/scan_status_pkg.sv
// Shared constants and carriers for the scan status register bank.
// Assumes one 250 MHz clock and a host sequencer that drives all ports.
package scan_status_pkg;

  // Register port geometry.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // Register word addresses on the plain register port.
  localparam logic [7:0] OFS_POT_ONE    = 8'h00;
  localparam logic [7:0] OFS_POT_TWO    = 8'h01;
  localparam logic [7:0] OFS_CONST_SCAN = 8'h02;
  localparam logic [7:0] OFS_STATUS     = 8'h03;
  localparam logic [7:0] OFS_CONTROL    = 8'h04;
  localparam logic [7:0] OFS_SLOT_BASE  = 8'h08;
  localparam logic [7:0] OFS_ANN_MIN    = 8'h10;

  // Values after reset.
  localparam logic [15:0] CONST_SCAN_RESET = 16'h0000;
  localparam logic [2:0]  CONTROL_RESET    = 3'h0;

  // Field positions in the control and status words.
  localparam int CTRL_CSCAN_BIT = 0;
  localparam int CTRL_SMON_BIT  = 1;
  localparam int CTRL_AMON_BIT  = 2;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_WAIT_BIT  = 1;

  // Constant-scan unit and the clock cycles that make it up.
  localparam int CSCAN_UNIT_MS = 1;
  localparam int CLK_PERIOD_NS = 4;
  localparam int MS_CYCLES     = CSCAN_UNIT_MS * 1000000 / CLK_PERIOD_NS;

  // Relay image geometry and the range boundaries.
  localparam int RELAY_W     = 12;
  localparam int WORD_BITS   = 16;
  localparam int IMAGE_WORDS = 256;
  localparam int SLOT_COUNT  = 8;
  localparam logic [11:0] ANN_FIRST_NUM  = 12'h384;
  localparam logic [11:0] ANN_LAST_NUM   = 12'h3e7;
  localparam logic [7:0]  LAST_WORD      = 8'hff;

  // Register port request.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } reg_req_t;

  // Relay image update from the sequencer.
  typedef struct packed {
    logic        valid;
    logic        on;
    logic [11:0] num;
  } relay_wr_t;

endpackage : scan_status_pkg

//--- hdl/relay_image_mem.sv
// Bit-writable image of the state relays, one word per 16 relays.
// Assumes the owner issues at most one bit write and one read per cycle.
module relay_image_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 256,
  parameter int AW    = 8,
  parameter int BW    = 4
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Bit write port.
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [BW-1:0]    wr_bit,
  input  wire logic             wr_val,
  // Registered read port.
  input  wire logic             rd_en,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data_ff
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [DEPTH-1:0] valid_ff;
  logic [WIDTH-1:0] old_word;
  logic [WIDTH-1:0] nxt_word;

  // A word never written reads as all off, so no array reset is needed.
  always_comb
  begin
    old_word = valid_ff[wr_addr] ? mem[wr_addr] : '0;
    nxt_word = old_word;
    nxt_word[wr_bit] = wr_val;
  end

  // Word storage.
  always_ff @(posedge clk)
  begin
    if (wr_en)
      mem[wr_addr] <= nxt_word;
  end

  // Written-word markers.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      valid_ff <= '0;
    else if (wr_en)
      valid_ff[wr_addr] <= 1'b1;
  end

  // Read data from a register.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rd_data_ff <= '0;
    else if (rd_en)
      rd_data_ff <= valid_ff[rd_addr] ? mem[rd_addr] : '0;
  end

endmodule : relay_image_mem

//--- hdl/lowest_bit_finder.sv
// Finds the lowest set bit of a word.
// Purely combinational; the caller registers whatever it keeps.
module lowest_bit_finder #(
  parameter int WIDTH = 16,
  parameter int IW    = 4
) (
  // Word to search.
  input  wire logic [WIDTH-1:0] word,
  // Result.
  output logic                  found,
  output logic      [IW-1:0]    idx
);

  // Walk downward so that the lowest set bit is the last to win.
  always_comb
  begin
    found = 1'b0;
    idx   = '0;
    for (int i = WIDTH - 1; i >= 0; i--)
    begin
      if (word[i])
      begin
        found = 1'b1;
        idx   = IW'(i);
      end
    end
  end

endmodule : lowest_bit_finder

//--- verification/scan_status_regs_bench.sv
// Self-checking bench for the scan status register bank.
// Assumes the design files and package are compiled first; the bench
// drives every port itself at the rising edge and needs no partner.
module scan_status_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;

  // Shortened millisecond so the constant-scan wait ends quickly.
  localparam int MS_SIM = 10;

  // Compares one value and counts the comparison.
  `define CHECK(name, exp, got) \
    begin \
      n_tests++; \
      if ((got) !== (exp)) \
      begin \
        n_mismatch++; \
        $display("mismatch %s expected %h seen %h", name, exp, got); \
      end \
    end

  logic                        clk;
  logic                        rst_n;
  scan_status_pkg::reg_req_t   req;
  logic [15:0]                 rdata;
  scan_status_pkg::relay_wr_t  relay;
  logic [7:0]                  pot_one;
  logic [7:0]                  pot_two;
  logic                        eos;
  logic                        busy;
  logic                        cwait;
  logic [15:0]                 got;
  int                          n_mismatch;
  int                          n_tests;
  // Nine step states, one more than the slots hold, and two annunciators.
  logic [11:0] step_list [9] = '{12'h003, 12'h005, 12'h011, 12'h383,
    12'h3e8, 12'h3e9, 12'h800, 12'hffe, 12'hfff};

  // Design under test with a short millisecond.
  scan_status_regs #(
    .MS_CYCLES (MS_SIM)
  ) uut (
    .clk                (clk),
    .rst_n              (rst_n),
    .reg_req            (req),
    .reg_rdata_ff       (rdata),
    .relay_wr           (relay),
    .front_pot_one      (pot_one),
    .front_pot_two      (pot_two),
    .end_of_scan        (eos),
    .scan_busy          (busy),
    .constant_scan_wait (cwait)
  );

  // Clock of 4 ns period.
  always #2 clk = ~clk;

  // One-cycle write strobe beside address and data.
  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
  endtask : reg_write

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk);
    req <= '0;
    #1;
    d = rdata;
  endtask : reg_read

  // Write strobe followed with no gap by a read strobe of the same word,
  // so the read sees the value stored by the write just before it.
  task automatic reg_write_read(input logic [7:0] a, input logic [15:0] d,
                                output logic [15:0] q);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk);
    req <= '0;
    #1;
    q = rdata;
  endtask : reg_write_read

  // Reads a register and compares it with the expected word.
  task automatic check_reg(input string name, input logic [7:0] a,
                           input logic [15:0] exp);
    logic [15:0] d;
    reg_read(a, d);
    `CHECK(name, exp, d)
  endtask : check_reg

  // One relay image update.
  task automatic set_relay(input logic [11:0] num, input logic on);
    @(posedge clk);
    relay <= '{valid: 1'b1, on: on, num: num};
    @(posedge clk);
    relay <= '0;
  endtask : set_relay

  // Pulses end of scan and checks that the sweep starts.
  task automatic scan_start;
    @(posedge clk);
    eos <= 1'b1;
    @(posedge clk);
    eos <= 1'b0;
    #1;
    `CHECK("scan_busy rise", 1'b1, busy)
  endtask : scan_start

  // Waits for the sweep to finish under a bounded count.
  task automatic scan_finish;
    int k;
    for (k = 0; k < 3000 && busy !== 1'b0; k++)
    begin
      @(posedge clk);
      #1;
    end
    `CHECK("scan_busy fall", 1'b0, busy)
  endtask : scan_finish

  // Compares all eight slots with an expected table.
  task automatic check_slots(input logic [15:0] exp [8]);
    int i;
    for (i = 0; i < 8; i++)
    begin
      check_reg("slot", scan_status_pkg::OFS_SLOT_BASE + 8'(i), exp[i]);
    end
  endtask : check_slots

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  // The whole run is a few thousand cycles; this bound is far above it.
  initial
  begin
    #100000;
    n_mismatch++;
    report_and_stop();
  end

  // Main test sequence.
  initial
  begin
    int i;
    clk = 1'b0;
    rst_n = 1'b0;
    req = '0;
    relay = '0;
    pot_one = 8'hff;
    pot_two = 8'h00;
    eos = 1'b0;
    n_mismatch = 0;
    n_tests = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;

    // Power-on values, an unmapped address and a refused write.
    check_reg("const_scan reset", scan_status_pkg::OFS_CONST_SCAN,
              16'h0000);
    check_reg("control reset", scan_status_pkg::OFS_CONTROL, 16'h0000);
    check_reg("unmapped", 8'h20, 16'h0000);
    reg_write(scan_status_pkg::OFS_POT_ONE, 16'h5a5a);
    $display("test reset values done");

    // Extreme potentiometer readings, then swapped to catch crossed wires.
    scan_start();
    scan_finish();
    check_reg("pot one max", scan_status_pkg::OFS_POT_ONE, 16'h00ff);
    check_reg("pot two min", scan_status_pkg::OFS_POT_TWO, 16'h0000);
    @(posedge clk);
    pot_one <= 8'h00;
    pot_two <= 8'hff;
    scan_start();
    scan_finish();
    check_reg("pot one min", scan_status_pkg::OFS_POT_ONE, 16'h0000);
    check_reg("pot two max", scan_status_pkg::OFS_POT_TWO, 16'h00ff);
    $display("test potentiometers done");

    // Program writes a duration, back to back with the read.
    reg_write_read(scan_status_pkg::OFS_CONST_SCAN, 16'hbeef, got);
    `CHECK("const_scan write", 16'hbeef, got)
    $display("test duration write done");

    // Nine step states and two annunciators with both monitors on.
    reg_write(scan_status_pkg::OFS_CONTROL, 16'h0006);
    for (i = 0; i < 9; i++)
    begin
      set_relay(step_list[i], 1'b1);
    end
    set_relay(12'h3b6, 1'b1);
    set_relay(12'h385, 1'b1);
    scan_start();
    scan_finish();
    check_slots('{16'h0003, 16'h0005, 16'h0011, 16'h0383, 16'h03e8,
                  16'h03e9, 16'h0800, 16'h0ffe});
    check_reg("ann min", scan_status_pkg::OFS_ANN_MIN, 16'h0385);
    $display("test ascending slots done");

    // Changes between scans stay hidden until the next refresh.
    set_relay(12'h003, 1'b0);
    set_relay(12'h385, 1'b0);
    repeat (20) @(posedge clk);
    check_reg("slot one held", scan_status_pkg::OFS_SLOT_BASE,
              16'h0003);
    check_reg("ann held", scan_status_pkg::OFS_ANN_MIN, 16'h0385);
    for (i = 1; i < 9; i++)
    begin
      if (i != 3 && i != 4 && i != 5)
      begin
        set_relay(step_list[i], 1'b0);
      end
    end
    scan_start();
    scan_finish();
    check_slots('{16'h0383, 16'h03e8, 16'h03e9, 16'h0000, 16'h0000,
                  16'h0000, 16'h0000, 16'h0000});
    check_reg("ann next", scan_status_pkg::OFS_ANN_MIN, 16'h03b6);
    $display("test refresh timing done");

    // State monitor off: slots hold although the image changed.
    reg_write(scan_status_pkg::OFS_CONTROL, 16'h0004);
    set_relay(12'h00a, 1'b1);
    scan_start();
    scan_finish();
    check_reg("slot one frozen", scan_status_pkg::OFS_SLOT_BASE,
              16'h0383);
    $display("test monitor enable done");

    // Three units of a shortened millisecond, measured from end of scan.
    reg_write(scan_status_pkg::OFS_CONST_SCAN, 16'h0003);
    // The annunciator monitor is off here, so its minimum must hold.
    reg_write(scan_status_pkg::OFS_CONTROL, 16'h0001);
    set_relay(12'h3b6, 1'b0);
    scan_start();
    check_reg("status waiting", scan_status_pkg::OFS_STATUS,
              16'h0003);
    `CHECK("wait pin set", 1'b1, cwait)
    repeat (3 * MS_SIM + 10) @(posedge clk);
    check_reg("status elapsed", scan_status_pkg::OFS_STATUS,
              16'h0001);
    `CHECK("wait pin clear", 1'b0, cwait)
    scan_finish();
    check_reg("ann frozen", scan_status_pkg::OFS_ANN_MIN, 16'h03b6);
    $display("test constant scan done");

    // A second reset restores the default duration and control.
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    check_reg("const_scan reload", scan_status_pkg::OFS_CONST_SCAN,
              16'h0000);
    check_reg("control reload", scan_status_pkg::OFS_CONTROL, 16'h0000);
    $display("test second reset done");
    report_and_stop();
  end

endmodule : scan_status_regs_bench
